// ---- src/fbpc_pkg.sv ----
// Constants, enumerations and state layout of the parameter/config handler
package fbpc_pkg;
  // Telegram kinds presented on the receive stream
  localparam logic [1:0] KIND_PRM = 2'h0;
  localparam logic [1:0] KIND_CFG = 2'h1;
  localparam logic [1:0] KIND_DX = 2'h2;
  // Parameter telegram octet numbers, zero based (octet 1 is index 0)
  localparam int PRM_LEN = 35;
  localparam int OCT_STAT = 0;
  localparam int OCT_WDF1 = 1;
  localparam int OCT_WDF2 = 2;
  localparam int OCT_SDR = 3;
  localparam int OCT_ID_HI = 4;
  localparam int OCT_ID_LO = 5;
  localparam int OCT_EXT1 = 7;
  localparam int OCT_EXT2 = 8;
  localparam int OCT_EXT3 = 9;
  localparam int OCT_TOOL = 10;
  localparam int OCT_PORT1 = 11;
  localparam int PRM_MIN_LEN = 6;
  // Station status bit positions
  localparam int ST_WD_ON = 3;
  localparam int ST_FREEZE = 4;
  localparam int ST_SYNC = 5;
  localparam int ST_UNLOCK = 6;
  localparam int ST_LOCK = 7;
  localparam int TOOL_P1 = 1;
  localparam int TOOL_P2 = 2;
  // Configuration limits and identifier byte layout
  localparam logic [3:0] MAX_MODULES = 4'h3;
  localparam int IO_BYTES = 4;
  localparam int CFG_OUT_BIT = 5;
  localparam int CFG_IN_BIT = 4;
  // Reply codes for parameter and configuration telegrams
  localparam logic [7:0] ACK_OK = 8'h01;
  localparam logic [7:0] ACK_NAK = 8'h00;
  // Timing: watchdog base and responder delay unit
  localparam int WD_BASE_MS = 10;
  localparam int CLK_MHZ = 250;
  localparam int WD_BASE_CYC_DEF = WD_BASE_MS * CLK_MHZ * 1000;
  localparam logic [15:0] SDR_UNIT_CYC = 16'h0004;
  // Arbitrary neutral identifier, replace per product
  localparam logic [15:0] IDENT_DEF = 16'hA5C3;
  // APB register byte offsets
  localparam logic [7:0] REG_IDENT = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_TIME = 8'h08;
  localparam logic [7:0] REG_EXT = 8'h0C;
  localparam logic [7:0] REG_OUT = 8'h10;
  localparam logic [7:0] REG_IN = 8'h14;
  localparam logic [7:0] REG_PORT = 8'h20;
  localparam logic [7:0] REG_PORT_END = 8'h34;
  localparam int STAT_TRIP = 8;

  typedef enum logic [1:0] {
    NS_WPRM = 2'b00, NS_WCFG = 2'b01, NS_DXCH = 2'b10
  } fbpc_node_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_SEND = 2'b10
  } fbpc_tx_t;

  typedef struct packed {
    fbpc_node_t ns;
    fbpc_tx_t ts;
    logic [PRM_LEN-1:0][7:0] shadow;
    logic [PRM_LEN-1:0][7:0] prm;
    logic [7:0] idx;
    logic bad;
    logic [3:0] ncfg;
    logic [4:0] cfg_out;
    logic [4:0] cfg_in;
    logic [4:0] out_len;
    logic [4:0] in_len;
    logic [IO_BYTES-1:0][7:0] out_sh;
    logic [IO_BYTES-1:0][7:0] out_q;
    logic [IO_BYTES-1:0][7:0] tx_buf;
    logic [2:0] tx_cnt;
    logic [2:0] tx_last_ix;
    logic [15:0] dly;
    logic [31:0] wd_base;
    logic [15:0] wd_units;
    logic wd_trip;
    logic [15:0] ident;
    logic locked;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
  } fbpc_state_t;
endpackage : fbpc_pkg

// ---- src/fbpc_node.sv ----
// Fieldbus slave handler for parameter, configuration and cyclic telegrams
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Parameter settings are taken from the octets of the parameter telegram.
// - Status bit 3 switches the response watchdog on or off.
// - Status bit 4 records the freeze request.
// - Status bit 5 records the sync request.
// - Bits 7:6 decode: 00 overwrite only, 10 lock, 01/11 release.
// - Watchdog time is 10 ms times factor octets 2 and 3.
// - Every reply waits at least the responder delay from octet 4.
// - Parameter telegram accepted only if octets 5-6 match own identifier.
// - Group octet 7 is ignored.
// - Octets 8 to 10 are kept as extended parameter status.
// - Octet 11 bits 1 and 2 give tool-change mode per device port.
// - Octets 12-23 and 24-35 hold module code and parameters per port.
// - Configuration holds at most three modules.
// - Output string length follows configured identifier bytes.
// - Cyclic octets drive outputs; reply carries the input data.
module fbpc_node
  import fbpc_pkg::*;
#(
  parameter int unsigned WD_BASE_CYC = WD_BASE_CYC_DEF
) (
  input wire logic CLK, // 250 MHz clock
  input wire logic RSTN, // Synchronous reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB write
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error, unmapped address
  input wire logic RX_VALID, // Received octet valid
  input wire logic [7:0] RX_DATA, // Received octet
  input wire logic RX_LAST, // Last octet of telegram
  input wire logic [1:0] RX_KIND, // Telegram kind
  output logic TX_VALID, // Reply octet valid
  output logic [7:0] TX_DATA, // Reply octet
  output logic TX_LAST, // Last reply octet
  input wire logic TX_READY, // Link takes reply octet
  output logic [31:0] OUT_DATA, // Valve and electrical outputs
  input wire logic [31:0] IN_DATA, // Device inputs
  output logic DX_ACTIVE, // Cyclic exchange running
  output logic WD_ON, // Watchdog enabled
  output logic FREEZE_REQ, // Freeze requested
  output logic SYNC_REQ, // Sync requested
  output logic LOCKED, // Blocked for other masters
  output logic [1:0] TOOL_CHG // Tool-change mode per port
);
  fbpc_state_t s_r;
  fbpc_state_t s_nxt;
  logic rx_end;
  logic id_ok;
  logic [7:0] id_lo;
  logic [15:0] wd_limit;
  logic [4:0] clen;
  logic apb_rd;
  logic apb_wr;
  logic [5:0] word_ix;

  ////////////////////////////////////////////////////////////////////////
  // Decodes shared by next-state logic and assertions
  assign rx_end = RX_VALID && RX_LAST;
  // A six-octet telegram ends on the low identifier octet itself
  assign id_lo = s_r.idx == OCT_ID_LO ? RX_DATA : s_r.shadow[OCT_ID_LO];
  assign id_ok = {s_r.shadow[OCT_ID_HI], id_lo} == s_r.ident;
  assign wd_limit = 16'({8'h00, s_r.prm[OCT_WDF1]} *
                        {8'h00, s_r.prm[OCT_WDF2]});
  assign apb_rd = PSEL && PENABLE && !s_r.pready;
  assign apb_wr = PSEL && PENABLE && s_r.pready && PWRITE;
  assign word_ix = 6'((PADDR - REG_PORT) >> 2);
  assign clen = 5'({1'b0, RX_DATA[3:0]} + 5'h01);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic for all state
  always_comb begin
    s_nxt = s_r;
    // APB: one wait state, read data registered on the same edge as ready
    s_nxt.pready = apb_rd;
    if (apb_rd) begin
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = 32'h0000_0000;
      unique case (PADDR)
        REG_IDENT: s_nxt.prdata = {16'h0000, s_r.ident};
        REG_STAT: s_nxt.prdata = {23'h00_0000, s_r.wd_trip,
                                  s_r.prm[OCT_STAT][ST_LOCK:ST_WD_ON],
                                  s_r.locked, s_r.ns};
        REG_TIME: s_nxt.prdata = {8'h00, s_r.prm[OCT_SDR],
                                  s_r.prm[OCT_WDF2], s_r.prm[OCT_WDF1]};
        REG_EXT: s_nxt.prdata = {s_r.prm[OCT_TOOL], s_r.prm[OCT_EXT3],
                                 s_r.prm[OCT_EXT2], s_r.prm[OCT_EXT1]};
        REG_OUT: s_nxt.prdata = s_r.out_q;
        REG_IN: s_nxt.prdata = IN_DATA;
        default: begin
          if (PADDR >= REG_PORT && PADDR <= REG_PORT_END &&
              PADDR[1:0] == 2'h0) begin
            // Module code and parameters of both ports, four per word
            s_nxt.prdata = {s_r.prm[OCT_PORT1 + 4 * word_ix + 3],
                            s_r.prm[OCT_PORT1 + 4 * word_ix + 2],
                            s_r.prm[OCT_PORT1 + 4 * word_ix + 1],
                            s_r.prm[OCT_PORT1 + 4 * word_ix]};
          end else begin
            s_nxt.pslverr = 1'b1;
          end
        end
      endcase
    end
    if (apb_wr && PADDR == REG_IDENT) begin
      s_nxt.ident = PWDATA[15:0];
    end
    // Trip flag: write one clears, a new trip below wins
    if (apb_wr && PADDR == REG_STAT && PWDATA[STAT_TRIP]) begin
      s_nxt.wd_trip = 1'b0;
    end

    // Receive stream: octet counter and per-kind capture
    if (RX_VALID) begin
      s_nxt.idx = RX_LAST ? 8'h00 : 8'(s_r.idx + 8'h01);
      unique case (RX_KIND)
        KIND_PRM: begin
          if (s_r.idx < PRM_LEN) begin
            s_nxt.shadow[s_r.idx] = RX_DATA;
          end
        end
        KIND_CFG: begin
          // Each identifier octet is one module
          s_nxt.ncfg = 4'(s_r.ncfg + 4'h1);
          if (RX_DATA[CFG_OUT_BIT]) begin
            s_nxt.cfg_out = 5'(s_r.cfg_out + clen);
          end
          if (RX_DATA[CFG_IN_BIT]) begin
            s_nxt.cfg_in = 5'(s_r.cfg_in + clen);
          end
        end
        default: begin
          if (s_r.idx < IO_BYTES) begin
            s_nxt.out_sh[s_r.idx[1:0]] = RX_DATA;
          end
        end
      endcase
    end

    // Telegram end: commit, check and build the reply
    if (rx_end && s_r.ts == TX_IDLE) begin
      s_nxt.ts = TX_WAIT;
      s_nxt.tx_cnt = 3'h0;
      s_nxt.tx_last_ix = 3'h0;
      s_nxt.tx_buf = '0;
      s_nxt.tx_buf[0] = ACK_NAK;
      // Reply delay taken from the octet in force, never below one cycle
      s_nxt.dly = 16'({8'h00, s_r.prm[OCT_SDR]} * SDR_UNIT_CYC);
      unique case (RX_KIND)
        KIND_PRM: begin
          if (id_ok && s_r.idx + 8'h01 >= PRM_MIN_LEN) begin
            s_nxt.tx_buf[0] = ACK_OK;
            // Group octet is copied with the rest but never read
            s_nxt.prm = s_r.shadow;
            s_nxt.prm[s_r.idx] = RX_DATA;
            if (s_r.shadow[OCT_STAT][ST_LOCK:ST_UNLOCK] == 2'b00) begin
              // Overwrite only: lock state of the node stays as it was
              s_nxt.prm[OCT_STAT][ST_LOCK:ST_UNLOCK] =
                s_r.prm[OCT_STAT][ST_LOCK:ST_UNLOCK];
            end else begin
              s_nxt.locked =
                s_r.shadow[OCT_STAT][ST_LOCK:ST_UNLOCK] == 2'b10;
            end
            // New parameters always force a fresh configuration check
            s_nxt.ns = NS_WCFG;
          end else begin
            s_nxt.ns = NS_WPRM;
          end
          s_nxt.out_q = '0;
        end
        KIND_CFG: begin
          if (s_r.ns != NS_WPRM && s_nxt.ncfg <= MAX_MODULES &&
              s_nxt.cfg_out <= IO_BYTES &&
              s_nxt.cfg_in <= IO_BYTES) begin
            s_nxt.tx_buf[0] = ACK_OK;
            s_nxt.out_len = s_nxt.cfg_out;
            s_nxt.in_len = s_nxt.cfg_in;
            s_nxt.ns = NS_DXCH;
          end else begin
            s_nxt.ns = s_r.ns == NS_WPRM ? NS_WPRM : NS_WCFG;
            s_nxt.out_q = '0;
          end
        end
        default: begin
          if (s_r.ns == NS_DXCH) begin
            // Only configured output bytes reach the pins
            for (int i = 0; i < IO_BYTES; i++) begin
              if (i < s_r.out_len) begin
                s_nxt.out_q[i] = i == s_r.idx ? RX_DATA
                                              : s_r.out_sh[i];
              end
            end
            s_nxt.tx_buf = IN_DATA;
            s_nxt.tx_buf[0] = s_r.in_len == 5'h00 ? ACK_OK : IN_DATA[7:0];
            if (s_r.in_len != 5'h00) begin
              s_nxt.tx_last_ix = 3'(s_r.in_len - 5'h01);
            end
            s_nxt.wd_base = 32'h0000_0000;
            s_nxt.wd_units = 16'h0000;
          end
        end
      endcase
      // Counters cleared only after the check has read the last octet
      s_nxt.ncfg = 4'h0;
      s_nxt.cfg_out = 5'h00;
      s_nxt.cfg_in = 5'h00;
    end

    // Reply sequencer: hold back, then stream with the link handshake
    unique case (s_r.ts)
      TX_IDLE: ;
      TX_WAIT: begin
        if (s_r.dly <= 16'h0001) begin
          s_nxt.ts = TX_SEND;
          s_nxt.tx_valid = 1'b1;
          s_nxt.tx_data = s_r.tx_buf[0];
          s_nxt.tx_last = s_r.tx_last_ix == 3'h0;
        end else begin
          s_nxt.dly = 16'(s_r.dly - 16'h0001);
        end
      end
      TX_SEND: begin
        if (TX_READY) begin
          if (s_r.tx_last) begin
            s_nxt.ts = TX_IDLE;
            s_nxt.tx_valid = 1'b0;
            s_nxt.tx_last = 1'b0;
          end else begin
            s_nxt.tx_cnt = 3'(s_r.tx_cnt + 3'h1);
            s_nxt.tx_data = s_r.tx_buf[s_nxt.tx_cnt[1:0]];
            s_nxt.tx_last = s_nxt.tx_cnt == s_r.tx_last_ix;
          end
        end
      end
      default: s_nxt.ts = TX_IDLE;
    endcase

    // Response watchdog, only while exchanging with monitoring on
    if (s_r.ns == NS_DXCH && s_r.prm[OCT_STAT][ST_WD_ON] &&
        !rx_end) begin
      if (s_r.wd_base >= WD_BASE_CYC - 1) begin
        s_nxt.wd_base = 32'h0000_0000;
        s_nxt.wd_units = 16'(s_r.wd_units + 16'h0001);
        if (s_nxt.wd_units >= wd_limit) begin
          // Loss of master: safe outputs, wait for new parameters
          s_nxt.ns = NS_WPRM;
          s_nxt.out_q = '0;
          s_nxt.wd_trip = 1'b1;
        end
      end else begin
        s_nxt.wd_base = 32'(s_r.wd_base + 32'h0000_0001);
      end
    end else if (s_r.ns != NS_DXCH) begin
      s_nxt.wd_base = 32'h0000_0000;
      s_nxt.wd_units = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s_r <= '0;
      s_r.ident <= IDENT_DEF;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs come straight from the state register
  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign TX_VALID = s_r.tx_valid;
  assign TX_DATA = s_r.tx_data;
  assign TX_LAST = s_r.tx_last;
  assign OUT_DATA = s_r.out_q;
  // Exchange is the only state with the upper state bit set
  assign DX_ACTIVE = s_r.ns[1];
  assign WD_ON = s_r.prm[OCT_STAT][ST_WD_ON];
  assign FREEZE_REQ = s_r.prm[OCT_STAT][ST_FREEZE];
  assign SYNC_REQ = s_r.prm[OCT_STAT][ST_SYNC];
  assign LOCKED = s_r.locked;
  assign TOOL_CHG = {s_r.prm[OCT_TOOL][TOOL_P2],
                     s_r.prm[OCT_TOOL][TOOL_P1]};

  ////////////////////////////////////////////////////////////////////////
  // Checks on the handler's own behaviour
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_prm_ok;
    rx_end && s_r.ts == TX_IDLE && RX_KIND == KIND_PRM && id_ok &&
      s_r.idx >= 8'h05;
  endsequence
  sequence s_reply_armed;
    s_r.ts == TX_IDLE ##1 s_r.ts == TX_WAIT;
  endsequence

  AST_WD_GATE: assert property (
    !WD_ON |=> s_r.wd_units == 16'h0000 || $past(s_r.ns) != NS_DXCH)
    else $error("watchdog ran while disabled");
  AST_FREEZE: assert property (
    s_prm_ok |=> FREEZE_REQ == $past(s_r.shadow[OCT_STAT][ST_FREEZE]))
    else $error("freeze request not recorded");
  AST_SYNC: assert property (
    s_prm_ok |=> SYNC_REQ == $past(s_r.shadow[OCT_STAT][ST_SYNC]))
    else $error("sync request not recorded");
  AST_LOCK: assert property (
    s_prm_ok and s_r.shadow[OCT_STAT][ST_LOCK:ST_UNLOCK] != 2'b00 |=>
      LOCKED == ($past(s_r.shadow[OCT_STAT][ST_LOCK:ST_UNLOCK]) == 2'b10))
    else $error("lock decode wrong");
  AST_WD_TRIP: assert property (
    $rose(s_r.wd_trip) |-> $past(s_r.wd_units) + 16'h0001 >= wd_limit &&
      !DX_ACTIVE && OUT_DATA == 32'h0000_0000)
    else $error("watchdog tripped early or left outputs on");
  AST_SDR: assert property (
    s_reply_armed ##0 $past(s_r.prm[OCT_SDR]) != 8'h00 |->
      (!TX_VALID && s_r.ts == TX_WAIT) [*4])
    else $error("reply sent before responder delay");
  AST_IDENT: assert property (
    rx_end && s_r.ts == TX_IDLE && RX_KIND == KIND_PRM && !id_ok |=>
      s_r.ns == NS_WPRM)
    else $error("foreign identifier accepted");
  AST_CFG_MAX: assert property (
    $rose(DX_ACTIVE) |-> $past(s_r.ncfg) < MAX_MODULES)
    else $error("exchange entered with too many modules");
  AST_DX_OUT: assert property (
    rx_end && s_r.ts == TX_IDLE && RX_KIND == KIND_DX && !DX_ACTIVE |=>
      OUT_DATA == $past(OUT_DATA))
    else $error("outputs changed outside cyclic exchange");
  AST_NO_DX: assert property (
    s_r.ns == NS_WPRM |=> s_r.ns != NS_DXCH)
    else $error("cyclic exchange without valid parameters");
endmodule : fbpc_node

// ---- testbench/fbpc_master_model.sv ----
// Behavioural bus master: sends telegrams, collects reply octets
`timescale 1ns/1ps
module fbpc_master_model (
  input wire logic CLK, // Clock
  input wire logic SLOW, // Stall reply every other cycle
  output logic RX_VALID, // Octet valid
  output logic [7:0] RX_DATA, // Octet
  output logic RX_LAST, // Last octet
  output logic [1:0] RX_KIND, // Telegram kind
  input wire logic TX_VALID, // Reply octet valid
  input wire logic [7:0] TX_DATA, // Reply octet
  input wire logic TX_LAST, // Last reply octet
  output logic TX_READY // Reply octet taken
);
  logic [7:0] rep [8];
  int nrep;
  int lat;
  logic done;
  logic cnt;
  initial begin
    {RX_VALID, RX_LAST, RX_KIND, RX_DATA, TX_READY, cnt, done} = '0;
    nrep = 0;
    lat = 0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Reply sink; slow mode exercises the held reply octet
  always @(posedge CLK) begin
    cnt <= !cnt;
    TX_READY <= !SLOW || cnt;
    if (TX_VALID && TX_READY && nrep < 8) begin
      rep[nrep] <= TX_DATA;
      nrep <= nrep + 1;
      done <= TX_LAST;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // One telegram, then a wait with no limit of its own for the whole reply
  task automatic send(input logic [1:0] k, input logic [7:0] t [64],
                      input int n);
    int w;
    nrep = 0;
    done = 0;
    for (int j = 0; j < n; j++) begin
      @(posedge CLK);
      RX_VALID <= 1'b1;
      RX_KIND <= k;
      RX_DATA <= t[j];
      RX_LAST <= (j == n - 1);
    end
    @(posedge CLK);
    RX_VALID <= 1'b0;
    RX_LAST <= 1'b0;
    // Stale data would hide a late sample, so show its inverse
    RX_DATA <= ~t[n-1];
    w = 0;
    // A reply that never comes is ended by the bench watchdog
    while (TX_VALID !== 1'b1) begin
      @(posedge CLK);
      w++;
    end
    lat = w;
    while (done !== 1'b1) begin
      @(posedge CLK);
      w++;
    end
  endtask : send
endmodule : fbpc_master_model

// ---- testbench/fieldbus_slave_param_cfg_handler_bench.sv ----
// Self-checking bench for the fieldbus parameter and config handler
`timescale 1ns/1ps
module fieldbus_slave_param_cfg_handler_bench;
  import fbpc_pkg::*;
  logic CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SLOW;
  logic [7:0] PADDR, RX_DATA, TX_DATA, st, d, f1, f2, dprev;
  logic [31:0] PWDATA, PRDATA, OUT_DATA, IN_DATA, rd;
  logic RX_VALID, RX_LAST, TX_VALID, TX_LAST, TX_READY, er, lk;
  logic [1:0] RX_KIND, TOOL_CHG, lb;
  logic DX_ACTIVE, WD_ON, FREEZE_REQ, SYNC_REQ, LOCKED;
  logic [7:0] b [64];
  logic [1:0] pat [6] = '{2'b10, 2'b00, 2'b01, 2'b10, 2'b11, 2'b00};
  int seed, err_count, compares, i;

  fbpc_node #(.WD_BASE_CYC(20)) fbpc_node_i (.CLK, .RSTN, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .RX_VALID,
    .RX_DATA, .RX_LAST, .RX_KIND, .TX_VALID, .TX_DATA, .TX_LAST, .TX_READY,
    .OUT_DATA, .IN_DATA, .DX_ACTIVE, .WD_ON, .FREEZE_REQ, .SYNC_REQ,
    .LOCKED, .TOOL_CHG);
  fbpc_master_model fbpc_master_model_i (.CLK, .SLOW, .RX_VALID, .RX_DATA,
    .RX_LAST, .RX_KIND, .TX_VALID, .TX_DATA, .TX_LAST, .TX_READY);

  initial begin
    CLK = 0;
    forever #2 CLK = ~CLK;
  end
  ////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and APB master
  task automatic check(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic test_done();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1;
    // Only the bench watchdog ends a missing answer
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask : apb
  // Telegram with the minimum responder delay check on its reply
  task automatic tel(input logic [1:0] k, input int n);
    fbpc_master_model_i.send(k, b, n);
    check("delay", fbpc_master_model_i.lat >= 4 * dprev, 1);
  endtask : tel
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 62;
    {RSTN, PSEL, PENABLE, PWRITE, PADDR, PWDATA, IN_DATA, SLOW} = '0;
    {err_count, compares, dprev, lb, lk} = '0;
    repeat (10) @(posedge CLK);
    RSTN <= 1;
    apb(0, REG_IDENT, 0);
    check("ident", rd, {16'h0000, IDENT_DEF});
    apb(0, REG_STAT, 0);
    check("status", rd, 0);
    apb(1, 8'h3C, 32'h0000_0001);
    check("slverr", er, 1);
    $display("reset test ended");
    // Foreign identifier must be refused
    b[4] = ~IDENT_DEF[15:8];
    b[5] = IDENT_DEF[7:0];
    tel(KIND_PRM, PRM_LEN);
    check("prm nak", fbpc_master_model_i.rep[0], ACK_NAK);
    apb(0, REG_STAT, 0);
    check("state", rd[1:0], 0);
    // Station byte sweep over every lock pattern, random fields
    for (int p = 0; p < 6; p++) begin
      for (i = 0; i < 35; i++) b[i] = 8'($random(seed));
      st = {pat[p], b[0][5:4], p == 5 ? 1'b1 : b[0][3], 3'b000};
      f1 = 8'h05 + {5'h00, b[1][2:0]};
      f2 = 8'h05 + {5'h00, b[2][2:0]};
      d = {5'h00, b[3][2:0]};
      {b[0], b[1], b[2], b[3]} = {st, f1, f2, d};
      {b[4], b[5]} = IDENT_DEF;
      SLOW <= p[0];
      tel(KIND_PRM, PRM_LEN);
      dprev = d;
      if (st[7:6] != 2'b00) lb = st[7:6];
      lk = (lb == 2'b10);
      check("prm ack", fbpc_master_model_i.rep[0], ACK_OK);
      check("wd on", WD_ON, st[3]);
      check("freeze", FREEZE_REQ, st[4]);
      check("sync", SYNC_REQ, st[5]);
      check("locked", LOCKED, lk);
      check("tool", TOOL_CHG, {b[10][2], b[10][1]});
      apb(0, REG_STAT, 0);
      check("status", rd, {24'h0, lb, st[5:3], lk, 2'b01});
      apb(0, REG_TIME, 0);
      check("time", rd, {8'h00, d, f2, f1});
      apb(0, REG_EXT, 0);
      check("ext", rd, {b[10], b[9], b[8], b[7]});
      for (i = 0; i < 6; i++) begin
        apb(0, REG_PORT + 8'(4 * i), 0);
        check("port", rd,
              {b[14+4*i], b[13+4*i], b[12+4*i], b[11+4*i]});
      end
    end
    $display("parameter test ended");
    // Four modules refused, then three accepted
    b[0:3] = '{8'h21, 8'h11, 8'h00, 8'h00};
    tel(KIND_CFG, 4);
    check("cfg nak", fbpc_master_model_i.rep[0], ACK_NAK);
    check("dx idle", DX_ACTIVE, 0);
    tel(KIND_CFG, 3);
    check("cfg ack", fbpc_master_model_i.rep[0], ACK_OK);
    check("dx on", DX_ACTIVE, 1);
    // Cyclic exchange, two output and two input octets
    for (int c = 0; c < 4; c++) begin
      b[0] = 8'($random(seed));
      b[1] = 8'($random(seed));
      IN_DATA <= $random(seed);
      SLOW <= c[0];
      tel(KIND_DX, 2);
      check("outputs", OUT_DATA, {16'h0000, b[1], b[0]});
      check("in0", fbpc_master_model_i.rep[0], IN_DATA[7:0]);
      check("in1", fbpc_master_model_i.rep[1], IN_DATA[15:8]);
      apb(0, REG_OUT, 0);
      check("out reg", rd, {16'h0000, b[1], b[0]});
      apb(0, REG_IN, 0);
      check("in reg", rd, IN_DATA);
    end
    $display("exchange test ended");
    // Silence past the monitoring time trips the watchdog
    repeat (int'(f1) * int'(f2) * 20 + 40) @(posedge CLK);
    check("trip dx", DX_ACTIVE, 0);
    check("trip out", OUT_DATA, 0);
    apb(0, REG_STAT, 0);
    check("trip flag", rd[STAT_TRIP], 1);
    apb(1, REG_STAT, 32'h0000_0100);
    apb(0, REG_STAT, 0);
    check("trip clr", rd[STAT_TRIP], 0);
    tel(KIND_DX, 2);
    check("dx nak", fbpc_master_model_i.rep[0], ACK_NAK);
    check("out kept", OUT_DATA, 0);
    apb(1, REG_IDENT, 32'h0000_1234);
    apb(0, REG_IDENT, 0);
    check("ident wr", rd, 32'h0000_1234);
    $display("watchdog test ended");
    test_done();
  end
  // Hang guard, far beyond the expected run
  initial begin
    repeat (60000) @(posedge CLK);
    err_count++;
    test_done();
  end
endmodule : fieldbus_slave_param_cfg_handler_bench
